//--- rtl/rx_pdo_cfg.svh
/*
 * Constants for the receive process-data unit: dictionary indices, defaults and field positions.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef RX_PDO_CFG_SVH
`define RX_PDO_CFG_SVH

// ----------------------------------------------------------------------------
// channel geometry
// ----------------------------------------------------------------------------
`define RX_CH          4
`define MAP_MAX        4
`define PAYLOAD_BITS   10'h040
`define PAYLOAD_W      64
`define COMM_LAST_SUB  32'h0000_0004

// ----------------------------------------------------------------------------
// dictionary indices
// ----------------------------------------------------------------------------
`define IDX_COMM       16'h1400
`define IDX_MAP        16'h1600
`define IDX_MFR_LO     16'h2000
`define IDX_MFR_HI     16'h5fff
`define SUB_COUNT      8'h00
`define SUB_COBID      8'h01
`define SUB_TTYPE      8'h02

// ----------------------------------------------------------------------------
// identifiers and defaults
// ----------------------------------------------------------------------------
`define COB_BASE0      11'h200
`define COB_STEP       11'h100
`define SYNC_ID        11'h080
`define SDO_RX_BASE    11'h600
`define SDO_TX_BASE    11'h580
`define COB_DIS_BIT    31
`define TT_SYNC_MAX    8'hf0
`define TT_ASYNC_LO    8'hfe
`define TT_DEFAULT     8'hfe
`define MAP_DEF_COUNT  8'h02
`define MAP_DEF_E0     32'h22ad_0010
`define MAP_DEF_E1     32'h22b8_0010

`endif

//--- rtl/rx_pdo_pkg.sv
/*
 * Types shared by the receive process-data unit and its surroundings.
 * Assumes rx_pdo_cfg.svh is on the include path.
 */
`include "rx_pdo_cfg.svh"

package rx_pdo_pkg;

    // one received bus frame; data byte 0 sits in bits 7:0
    typedef struct packed {
        logic                     valid;
        logic                     rtr;
        logic [10:0]              id;
        logic [3:0]               dlc;
        logic [`PAYLOAD_W-1:0]    data;
    } can_frame_t;

    // service-data access to the dictionary
    typedef struct packed {
        logic                     valid;
        logic                     we;
        logic                     target_ro;
        logic [15:0]              index;
        logic [7:0]               sub;
        logic [31:0]              data;
    } cfg_req_t;

    typedef struct packed {
        logic                     ack;
        logic                     err;
        logic [31:0]              rdata;
    } cfg_resp_t;

    // one mapped object update
    typedef struct packed {
        logic                     valid;
        logic [15:0]              index;
        logic [7:0]               sub;
        logic [7:0]               size;
        logic [`PAYLOAD_W-1:0]    value;
    } obj_write_t;

    typedef enum logic {ST_IDLE, ST_EMIT} apply_state_t;

endpackage : rx_pdo_pkg

//--- rtl/canopen_receive_pdo_unit.sv
/*
 * Receive process-data unit: identifier filter, sync/async apply, mapping dictionary.
 * Assumes frames, config requests and the network state arrive synchronous to clk_sys.
 */
`include "rx_pdo_cfg.svh"

// Operation
// - service writes at index 2000h and above raise a nonvolatile commit; others are volatile
// - frame integers are least significant byte first
// - process data is consumed only while the network state is operational
// - payload carries no index; mapping list alone gives its meaning
// - read-only objects 2000h-5FFFh cannot be mapped into receive channels
// - four receive channels, up to eight payload bytes each
// - channel identifiers default to 200h/300h/400h/500h plus node address
// - a channel captures a frame only when identifiers are equal
// - identifier bit 31 set disables the channel
// - types 0-240 capture at once, apply at next SYNC
// - types 254 and 255 apply immediately after reception
// - entry count 0 disables the channel, 1 to 4 gives valid entries
// - at most four entries totalling eight bytes
// - entry is index 16 bits, sub-index 8 bits, size in bits 8 bits
// - remap by writing count 0, entries, then nonzero count re-enabling
// - default mapping is 22ADh.0 and 22B8h.0, 16 bits each; only channel 0 loads it, the others start with count 0
// - service requests use 600h plus node, replies 580h plus node
module canopen_receive_pdo_unit
    import rx_pdo_pkg::*;
#(
    parameter int NUM_CH = `RX_CH
) (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic        ce,
    input  wire logic [6:0]  node_id,
    input  wire logic        nmt_operational,
    input  wire can_frame_t  frame,
    input  wire cfg_req_t    cfg_req,
    output cfg_resp_t        cfg_resp,
    output obj_write_t       obj_wr,
    output logic             nv_commit,
    output logic             sdo_request,
    output logic [10:0]      sdo_reply_id
);

    localparam int CW = $clog2(NUM_CH);

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    // total mapped bits of the first n entries
    function automatic logic [9:0] map_bits(input logic [`MAP_MAX-1:0][31:0] ent,
                                            input logic [7:0] n);
        logic [9:0] sum;
        sum = '0;
        for (int e = 0; e < `MAP_MAX; e++) begin
            if (e < n) sum = sum + {2'b00, ent[e][7:0]};
        end
        return sum;
    endfunction : map_bits

    function automatic logic [`PAYLOAD_W-1:0] low_mask(input logic [7:0] size);
        logic [`PAYLOAD_W-1:0] m;
        m = (size >= 8'(`PAYLOAD_W)) ? '1 : ((`PAYLOAD_W'(1) << size) - `PAYLOAD_W'(1));
        return m;
    endfunction : low_mask

    // ------------------------------------------------------------------------
    // configuration state
    // ------------------------------------------------------------------------
    logic [NUM_CH-1:0][31:0]               cob,   next_cob;
    logic [NUM_CH-1:0][7:0]                ttype, next_ttype;
    logic [NUM_CH-1:0][7:0]                cnt,   next_cnt;
    logic [NUM_CH-1:0][`MAP_MAX-1:0][31:0] map,   next_map;
    logic                                  init_done, next_init_done;
    cfg_resp_t                             next_resp;
    logic                                  next_nv;
    logic [10:0]                           next_reply_id;

    // defaults need the node address, so they load on the first enabled edge after reset
    always_comb begin
        logic [CW-1:0] ch;
        logic [2:0]    es;
        ch             = '0;
        es             = '0;
        next_cob       = cob;
        next_ttype     = ttype;
        next_cnt       = cnt;
        next_map       = map;
        next_init_done = init_done;
        next_resp      = '0;
        next_nv        = 1'b0;
        next_reply_id  = `SDO_TX_BASE + {4'h0, node_id};
        if (!init_done) begin
            next_init_done = 1'b1;
            next_map       = '0;
            next_cnt       = '0;
            for (int c = 0; c < NUM_CH; c++) begin
                next_cob[c]   = {21'h0, `COB_BASE0 + 11'(c) * `COB_STEP + {4'h0, node_id}};
                next_ttype[c] = `TT_DEFAULT;
            end
            next_cnt[0]    = `MAP_DEF_COUNT;
            next_map[0][0] = `MAP_DEF_E0;
            next_map[0][1] = `MAP_DEF_E1;
        end else if (cfg_req.valid) begin
            next_resp.ack = 1'b1;
            ch            = cfg_req.index[CW-1:0];
            es            = cfg_req.sub[2:0] - 3'h1;
            if (cfg_req.index >= `IDX_COMM && cfg_req.index < `IDX_COMM + 16'(NUM_CH)) begin
                if (cfg_req.sub == `SUB_COBID) begin
                    if (cfg_req.we) next_cob[ch] = cfg_req.data;
                    else next_resp.rdata = cob[ch];
                end else if (cfg_req.sub == `SUB_TTYPE) begin
                    if (cfg_req.we) next_ttype[ch] = cfg_req.data[7:0];
                    else next_resp.rdata = {24'h0, ttype[ch]};
                end else if (cfg_req.sub == `SUB_COUNT && !cfg_req.we) begin
                    next_resp.rdata = `COMM_LAST_SUB;
                end else begin
                    next_resp.err = 1'b1;
                end
            end else if (cfg_req.index >= `IDX_MAP
                         && cfg_req.index < `IDX_MAP + 16'(NUM_CH)) begin
                if (cfg_req.sub == `SUB_COUNT) begin
                    if (!cfg_req.we) begin
                        next_resp.rdata = {24'h0, cnt[ch]};
                    // nonzero count only from zero and only if it fits eight bytes
                    end else if (cfg_req.data <= 32'(`MAP_MAX) && (cfg_req.data == '0
                                 || (cnt[ch] == '0 && map_bits(map[ch], cfg_req.data[7:0])
                                     <= `PAYLOAD_BITS))) begin
                        next_cnt[ch] = cfg_req.data[7:0];
                    end else begin
                        next_resp.err = 1'b1;
                    end
                end else if (cfg_req.sub <= 8'(`MAP_MAX)) begin
                    if (!cfg_req.we) begin
                        next_resp.rdata = map[ch][es[1:0]];
                    end else if (cnt[ch] != '0) begin
                        next_resp.err = 1'b1;
                    end else if (cfg_req.target_ro && cfg_req.data[31:16] >= `IDX_MFR_LO
                                 && cfg_req.data[31:16] <= `IDX_MFR_HI) begin
                        next_resp.err = 1'b1;
                    end else begin
                        next_map[ch][es[1:0]] = cfg_req.data;
                    end
                end else begin
                    next_resp.err = 1'b1;
                end
            end else if (cfg_req.index >= `IDX_MFR_LO && cfg_req.we) begin
                next_nv = 1'b1;
            end else begin
                next_resp.err = 1'b1; // nothing else is held or persisted here
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cob          <= '0;
            ttype        <= '0;
            cnt          <= '0;
            map          <= '0;
            init_done    <= 1'b0;
            cfg_resp     <= '0;
            nv_commit    <= 1'b0;
            sdo_reply_id <= '0;
        end else if (ce) begin
            cob          <= next_cob;
            ttype        <= next_ttype;
            cnt          <= next_cnt;
            map          <= next_map;
            init_done    <= next_init_done;
            cfg_resp     <= next_resp;
            nv_commit    <= next_nv;
            sdo_reply_id <= next_reply_id;
        end
    end

    // ------------------------------------------------------------------------
    // reception and apply engine
    // ------------------------------------------------------------------------
    logic [NUM_CH-1:0][`PAYLOAD_W-1:0] buf_data, next_buf_data;
    logic [NUM_CH-1:0]                 pend,     next_pend;
    logic [NUM_CH-1:0]                 apply,    next_apply;
    apply_state_t                      state,    next_state;
    logic [CW-1:0]                     cur,      next_cur;
    logic [2:0]                        ent,      next_ent;
    logic [`PAYLOAD_W-1:0]             shift,    next_shift;
    obj_write_t                        next_obj;
    logic                              next_sdo;

    // engine clears come first so that a capture in the same cycle wins
    always_comb begin
        logic [31:0] e;
        e             = map[cur][ent[1:0]];
        next_buf_data = buf_data;
        next_pend     = pend;
        next_apply    = apply;
        next_state    = state;
        next_cur      = cur;
        next_ent      = ent;
        next_shift    = shift;
        next_obj      = '0;
        next_sdo      = 1'b0;
        case (state)
            ST_IDLE: begin
                if (|apply) begin
                    for (int c = NUM_CH - 1; c >= 0; c--) begin
                        if (apply[c]) next_cur = CW'(c);
                    end
                    next_shift            = buf_data[next_cur];
                    next_apply[next_cur]  = 1'b0;
                    next_ent              = '0;
                    next_state            = ST_EMIT;
                end
            end
            ST_EMIT: begin
                // lowest bits go to the earliest entry, then the rest shifts down
                next_obj.valid = 1'b1;
                next_obj.index = e[31:16];
                next_obj.sub   = e[15:8];
                next_obj.size  = e[7:0];
                next_obj.value = shift & low_mask(e[7:0]);
                next_shift     = shift >> e[7:0];
                next_ent       = ent + 3'h1;
                if ({5'h0, ent + 3'h1} >= cnt[cur]) next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
        if (frame.valid && nmt_operational && !frame.rtr) begin
            // an empty frame on the sync identifier releases held captures
            if (frame.id == `SYNC_ID && frame.dlc == 4'h0) begin
                next_apply = next_apply | pend;
                next_pend  = '0;
            end
            if (frame.id == `SDO_RX_BASE + {4'h0, node_id}) next_sdo = 1'b1;
            for (int c = 0; c < NUM_CH; c++) begin
                if (!cob[c][`COB_DIS_BIT] && cnt[c] != '0
                    && frame.id == cob[c][10:0]
                    && {3'h0, frame.dlc, 3'h0} >= map_bits(map[c], cnt[c])) begin
                    if (ttype[c] <= `TT_SYNC_MAX) begin
                        next_buf_data[c] = frame.data;
                        next_pend[c]     = 1'b1;
                    end else if (ttype[c] >= `TT_ASYNC_LO) begin
                        next_buf_data[c] = frame.data;
                        next_apply[c]    = 1'b1;
                    end
                end
            end
        end
        // leaving operational drops anything still waiting
        if (!nmt_operational) begin
            next_pend  = '0;
            next_apply = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            buf_data    <= '0;
            pend        <= '0;
            apply       <= '0;
            state       <= ST_IDLE;
            cur         <= '0;
            ent         <= '0;
            shift       <= '0;
            obj_wr      <= '0;
            sdo_request <= 1'b0;
        end else if (ce) begin
            buf_data    <= next_buf_data;
            pend        <= next_pend;
            apply       <= next_apply;
            state       <= next_state;
            cur         <= next_cur;
            ent         <= next_ent;
            shift       <= next_shift;
            obj_wr      <= next_obj;
            sdo_request <= next_sdo;
        end
    end

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    logic hit0;
    assign hit0 = frame.valid && nmt_operational && !frame.rtr && init_done
                  && frame.id == cob[0][10:0] && cnt[0] != '0 && frame.id != `SYNC_ID;

    a_nv_commit_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && cfg_req.valid && cfg_req.we && init_done && cfg_req.index >= `IDX_MFR_LO
        |=> nv_commit)
        else $error("manufacturer write did not commit");

    a_offline_drop: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && !nmt_operational |=> pend == '0 && apply == '0)
        else $error("process data held while not operational");

    a_disabled_ch: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && hit0 && cob[0][`COB_DIS_BIT] && !pend[0] && !apply[0]
        |=> !pend[0] && !apply[0])
        else $error("disabled channel captured a frame");

    a_short_frame: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && hit0 && !pend[0] && !apply[0]
        && {3'h0, frame.dlc, 3'h0} < map_bits(map[0], cnt[0])
        |=> !pend[0] && !apply[0])
        else $error("short frame was captured");

    a_sync_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && hit0 && !cob[0][`COB_DIS_BIT] && ttype[0] <= `TT_SYNC_MAX && !apply[0]
        && {3'h0, frame.dlc, 3'h0} >= map_bits(map[0], cnt[0])
        |=> pend[0] && !apply[0])
        else $error("synchronous capture not held for sync");

    a_async_apply: assert property (@(posedge clk_sys) disable iff (!nrst || !ce)
        hit0 && !cob[0][`COB_DIS_BIT] && ttype[0] >= `TT_ASYNC_LO
        && {3'h0, frame.dlc, 3'h0} >= map_bits(map[0], cnt[0])
        |=> apply[0] ##[1:3] obj_wr.valid)
        else $error("asynchronous frame not applied");

    a_remap_guard: assert property (@(posedge clk_sys) disable iff (!nrst)
        ce && init_done && cfg_req.valid && cfg_req.we && cfg_req.index == `IDX_MAP
        && cfg_req.sub != `SUB_COUNT && cfg_req.sub <= 8'(`MAP_MAX) && cnt[0] != '0
        |=> cfg_resp.err && $stable(map[0]))
        else $error("entry changed while channel enabled");

    a_map_fits: assert property (@(posedge clk_sys) disable iff (!nrst)
        cnt[0] <= 8'(`MAP_MAX) && map_bits(map[0], cnt[0]) <= `PAYLOAD_BITS)
        else $error("mapping exceeds eight bytes");

    a_default_ids: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(init_done) |-> cob[1][10:0] == `COB_BASE0 + `COB_STEP + {4'h0, $past(node_id)})
        else $error("default identifier wrong");

    c_async: cover property (@(posedge clk_sys) disable iff (!nrst)
        apply[0] ##[1:4] obj_wr.valid);
    // sync clears pend and raises apply on one edge, so both show in the same sample
    c_sync: cover property (@(posedge clk_sys) disable iff (!nrst) $fell(pend[0]) && apply[0]);
    c_refused: cover property (@(posedge clk_sys) disable iff (!nrst) cfg_resp.err);
    c_commit: cover property (@(posedge clk_sys) disable iff (!nrst) nv_commit);

endmodule : canopen_receive_pdo_unit

//--- verification/can_node_model.sv
/*
 * Far-side model: a bus node that sends data frames and SYNC frames to the receive unit.
 * Assumes the bench supplies clk_sys and calls send from its own sequence.
 */
module can_node_model
    import rx_pdo_pkg::*;
(
    input  wire logic clk_sys,
    output can_frame_t frame
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // frame launcher
    // ------------------------------------------------------------------------
    initial frame = '0;

    // one frame for one cycle; the caller packs payload bytes lsb first
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
        @(negedge clk_sys);
        frame <= '{1'b1, 1'b0, id, dlc, data};
        @(negedge clk_sys);
        // idle bus shows inverted leftovers, so a stale payload never looks fresh
        frame <= '{1'b0, 1'b0, ~id, dlc, ~data};
    endtask : send
endmodule : can_node_model

//--- verification/tb.sv
/*
 * Self-checking bench for the receive process-data unit.
 * Assumes the design files and rx_pdo_cfg.svh are on the include path.
 */
`include "rx_pdo_cfg.svh"

module tb
    import rx_pdo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------------
    localparam logic [6:0]  NODE = 7'h05;
    localparam logic [10:0] ID0  = 11'h205;
    logic        clk_sys;
    logic        nrst;
    logic        ce;
    logic        nmt_operational;
    can_frame_t  frame;
    cfg_req_t    cfg_req;
    cfg_resp_t   cfg_resp;
    obj_write_t  obj_wr;
    logic        nv_commit;
    logic        sdo_request;
    logic [10:0] sdo_reply_id;
    obj_write_t  wq[$];
    int          n_fail;
    int          checks_done;
    int          n_nv;
    int          n_sdo;
    logic [31:0] rd;

    canopen_receive_pdo_unit u_canopen_receive_pdo_unit (.clk_sys(clk_sys), .nrst(nrst),
        .ce(ce), .node_id(NODE), .nmt_operational(nmt_operational), .frame(frame),
        .cfg_req(cfg_req), .cfg_resp(cfg_resp), .obj_wr(obj_wr), .nv_commit(nv_commit),
        .sdo_request(sdo_request), .sdo_reply_id(sdo_reply_id));
    can_node_model u_can_node_model (.clk_sys(clk_sys), .frame(frame));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // collect object updates and pulses as they come
    always @(posedge clk_sys) begin
        if (obj_wr.valid === 1'b1) wq.push_back(obj_wr);
        if (nv_commit === 1'b1) n_nv++;
        if (sdo_request === 1'b1) n_sdo++;
    end

    // ------------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : test_done

    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (ok !== 1'b1) begin
            $display("wrong value at %0t: %s", $time, m);
            n_fail++;
        end
    endtask : chk

    // pulse one request, then wait a bounded time for its answer
    task automatic cfg(input logic we, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, input logic ro = 1'b0, input logic err = 1'b0);
        int i;
        @(negedge clk_sys);
        cfg_req <= '{1'b1, we, ro, idx, sub, d};
        @(negedge clk_sys);
        cfg_req.valid <= 1'b0;
        for (i = 0; i < 4 && cfg_resp.ack !== 1'b1; i++) @(negedge clk_sys);
        chk(cfg_resp.ack === 1'b1 && cfg_resp.err === err, "config answer");
        // a lost answer has already counted as a mismatch; stop rather than hang on
        if (cfg_resp.ack !== 1'b1) test_done();
        rd = cfg_resp.rdata;
        @(negedge clk_sys);
    endtask : cfg

    task automatic rchk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] e);
        cfg(1'b0, idx, sub, 32'h0);
        chk(rd === e, "read back");
    endtask : rchk

    task automatic take(input logic [15:0] idx, input logic [7:0] size, input logic [63:0] v);
        obj_write_t o;
        for (int i = 0; i < 12 && wq.size() == 0; i++) @(negedge clk_sys);
        if (wq.size() == 0) begin
            chk(1'b0, "object update missing");
            test_done();
        end
        o = wq.pop_front();
        chk(o.index === idx && o.sub === 8'h00 && o.size === size && o.value === v, "update");
    endtask : take

    task automatic quiet();
        repeat (12) @(negedge clk_sys);
        chk(wq.size() == 0, "unexpected object update");
    endtask : quiet

    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_defaults();
        for (int c = 0; c < 4; c++) begin
            rchk(16'h1400 + 16'(c), 8'h01, 32'h200 + 32'h100 * c + 32'(NODE));
            rchk(16'h1400 + 16'(c), 8'h02, 32'hfe);
        end
        rchk(16'h1400, 8'h00, 32'h4);
        rchk(16'h1600, 8'h00, 32'h2);
        rchk(16'h1600, 8'h01, 32'h22ad_0010);
        rchk(16'h1600, 8'h02, 32'h22b8_0010);
        rchk(16'h1601, 8'h00, 32'h0);
    endtask : t_defaults

    task automatic t_async();
        u_can_node_model.send(ID0, 4'h4, 64'h0000_0000_1234_03e7);
        take(16'h22ad, 8'h10, 64'h03e7);
        take(16'h22b8, 8'h10, 64'h1234);
        u_can_node_model.send(ID0 + 11'h1, 4'h8, 64'h1);
        u_can_node_model.send(ID0, 4'h3, 64'h2);
        quiet();
    endtask : t_async

    task automatic t_sync_and_gate();
        cfg(1'b1, 16'h1400, 8'h02, 32'h0);
        u_can_node_model.send(ID0, 4'h4, 64'h5555_6666);
        quiet();
        u_can_node_model.send(`SYNC_ID, 4'h0, 64'h0);
        take(16'h22ad, 8'h10, 64'h6666);
        take(16'h22b8, 8'h10, 64'h5555);
        cfg(1'b1, 16'h1400, 8'h02, 32'hff);
        cfg(1'b1, 16'h1400, 8'h01, 32'h8000_0000 | 32'(ID0));
        u_can_node_model.send(ID0, 4'h4, 64'h7);
        quiet();
        cfg(1'b1, 16'h1400, 8'h01, 32'(ID0));
        nmt_operational <= 1'b0;
        u_can_node_model.send(ID0, 4'h4, 64'h8);
        quiet();
        nmt_operational <= 1'b1;
        u_can_node_model.send(ID0, 4'h4, 64'h0009_000a);
        take(16'h22ad, 8'h10, 64'h000a);
        take(16'h22b8, 8'h10, 64'h0009);
    endtask : t_sync_and_gate

    task automatic t_remap();
        cfg(1'b1, 16'h1600, 8'h01, 32'h2100_0020, 1'b0, 1'b1);
        cfg(1'b1, 16'h1600, 8'h00, 32'h0);
        u_can_node_model.send(ID0, 4'h8, 64'h1);
        quiet();
        cfg(1'b1, 16'h1600, 8'h01, 32'h2100_0020, 1'b1, 1'b1);
        cfg(1'b1, 16'h1600, 8'h01, 32'h2100_0020);
        cfg(1'b1, 16'h1600, 8'h02, 32'h2101_0040);
        cfg(1'b1, 16'h1600, 8'h00, 32'h2, 1'b0, 1'b1);
        cfg(1'b1, 16'h1600, 8'h00, 32'h5, 1'b0, 1'b1);
        cfg(1'b1, 16'h1600, 8'h02, 32'h2101_0020);
        cfg(1'b1, 16'h1600, 8'h00, 32'h2);
        u_can_node_model.send(ID0, 4'h8, 64'h8765_4321_dcba_9876);
        take(16'h2100, 8'h20, 64'hdcba_9876);
        take(16'h2101, 8'h20, 64'h8765_4321);
        // a second channel works on its own identifier and mapping
        cfg(1'b1, 16'h1601, 8'h01, 32'h2200_0008);
        cfg(1'b1, 16'h1601, 8'h00, 32'h1);
        u_can_node_model.send(ID0 + 11'h100, 4'h1, 64'h5a);
        take(16'h2200, 8'h08, 64'h5a);
    endtask : t_remap

    task automatic t_service();
        n_nv = 0;
        n_sdo = 0;
        cfg(1'b1, 16'h2000, 8'h00, 32'd999);
        cfg(1'b1, 16'h1400, 8'h02, 32'hfe);
        cfg(1'b0, 16'h2000, 8'h00, 32'h0, 1'b0, 1'b1);
        cfg(1'b1, 16'h1000, 8'h00, 32'h0, 1'b0, 1'b1);
        chk(n_nv == 1, "nonvolatile commit count");
        u_can_node_model.send(`SDO_RX_BASE + 11'(NODE), 4'h8, 64'h40);
        repeat (4) @(negedge clk_sys);
        chk(n_sdo == 1, "service request pulse");
        chk(sdo_reply_id === 11'h580 + 11'(NODE), "reply identifier");
    endtask : t_service

    // a low enable freezes the unit, so a matching frame in that window is never seen
    task automatic t_freeze();
        ce <= 1'b0;
        u_can_node_model.send(ID0, 4'h8, 64'h3);
        ce <= 1'b1;
        quiet();
    endtask : t_freeze

    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        n_fail = 0;
        checks_done = 0;
        nrst = 1'b0;
        nmt_operational = 1'b1;
        ce = 1'b1;
        cfg_req = '0;
        repeat (10) @(negedge clk_sys);
        nrst <= 1'b1;
        // the first enabled edge loads defaults and drops any request
        repeat (3) @(negedge clk_sys);
        t_defaults();
        t_async();
        t_sync_and_gate();
        t_remap();
        t_service();
        t_freeze();
        test_done();
    end
endmodule : tb
